// *** core/sfpm_core.sv ***
// Serial flash front end: frame decoder, status and configuration registers, pin functions.
`timescale 1ns/1ps
module sfpm_core (
	input wire logic clk,
	input wire logic resetn,
	input wire logic sckPin,
	input wire logic csnPin,
	input wire logic [3:0] laneIn,
	output logic [3:0] laneOut,
	output logic [3:0] laneOe,
	input wire logic restartPinN,
	input wire logic opStart,
	input wire logic opIsErase,
	input wire logic opDone,
	input wire logic opFail,
	input wire logic opProtected,
	output logic [7:0] statusOne,
	output logic [7:0] configOne,
	output logic [7:0] configTwo,
	output logic progErr,
	output logic eraseErr,
	output logic writeInProgress,
	output logic lane2IsGuard,
	output logic lane3IsRestart
);
	// All state of the front end.
	typedef struct packed {
		sfpm_pkg::sfpm_state_t state;
		logic sckPrev;
		logic csPrev;
		logic [7:0] opcode;
		logic [7:0] shiftIn;
		logic [3:0] bitCnt;
		logic [1:0] byteCnt;
		logic [7:0] dataOne;
		logic [7:0] dataTwo;
		logic [7:0] dataThree;
		logic [7:0] shiftOut;
		logic [3:0] outCnt;
		logic [3:0] laneOut;
		logic [7:0] statusOne;
		logic [7:0] statusOneNv;
		logic [7:0] configOne;
		logic [7:0] configOneNv;
		logic [7:0] configTwo;
		logic progErr;
		logic eraseErr;
		logic opErase;
	} sfpm_core_t;
	sfpm_core_t s;
	sfpm_core_t next_s;

	logic sckS; // Synchronised serial clock.
	logic csnS; // Synchronised chip select, high when deselected.
	logic [3:0] laneS; // Synchronised data lanes.
	logic restartSyncN; // Synchronised dedicated restart pin, active low.
	logic sckRise; // Serial clock rising edge seen this cycle.
	logic sckFall; // Serial clock falling edge seen this cycle.
	logic csFall; // Start of a frame.
	logic csRise; // End of a frame.
	logic nibble; // All transfers four bits wide.
	logic [3:0] step; // Bits moved per serial clock edge.
	logic [3:0] nextCnt; // Bit count after this edge.
	logic [7:0] shifted; // Input shift register after this edge.
	logic lane2Data; // Lane two is a data lane.
	logic lane3Data; // Lane three is a data lane.
	logic guardLow; // Write guard pin holds register writes off.
	logic restartNow; // Either restart source is asserted.
	logic writeOk; // A complete register write may be applied.

	// Every pin crosses into the clock domain; the serial clock idles low, the others high.
	sfpm_sync #(.INIT(1'b0)) u_sync_sck (.clk(clk), .resetn(resetn), .din(sckPin), .dout(sckS));
	sfpm_sync #(.INIT(1'b1)) u_sync_csn (.clk(clk), .resetn(resetn), .din(csnPin), .dout(csnS));
	sfpm_sync #(.INIT(1'b1)) u_sync_rst (.clk(clk), .resetn(resetn), .din(restartPinN), .dout(restartSyncN));
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_lane
			sfpm_sync #(.INIT(1'b1)) u_sync_lane (.clk(clk), .resetn(resetn), .din(laneIn[gi]), .dout(laneS[gi]));
		end
	endgenerate

	// Pin functions follow the volatile configuration, the nonvolatile protect bit and the select level.
	sfpm_pin_mux u_pin_mux (
		.quadMode(s.configOne[sfpm_pkg::CR1_QUAD]),
		.nibbleMode(s.configTwo[sfpm_pkg::CR2_NIBBLE]),
		.restartEnable(s.configTwo[sfpm_pkg::CR2_RESTART_EN]),
		.protectNv(s.statusOneNv[sfpm_pkg::SR1_PROTECT]),
		.csHigh(csnS),
		.lane2Guard(lane2IsGuard),
		.lane2Data(lane2Data),
		.lane3Data(lane3Data),
		.lane3Restart(lane3IsRestart)
	);

	// Edge detection against the copies held from the previous cycle.
	assign sckRise = sckS && !s.sckPrev;
	assign sckFall = !sckS && s.sckPrev;
	assign csFall = !csnS && s.csPrev;
	assign csRise = csnS && !s.csPrev;
	assign nibble = s.configTwo[sfpm_pkg::CR2_NIBBLE];
	assign step = nibble ? sfpm_pkg::STEP_NIBBLE : sfpm_pkg::STEP_SINGLE;
	assign nextCnt = s.bitCnt + step;
	assign shifted = nibble ? {s.shiftIn[3:0], laneS} : {s.shiftIn[6:0], laneS[0]};
	// The guard is sampled at the end of the write; the host holds it for the whole frame.
	assign guardLow = lane2IsGuard && !laneS[2];
	// A low restart level acts only when the lane is in its restart role.
	// While a nibble frame is selected the lane carries data, so its low bits must not abort the frame.
	assign restartNow = !restartSyncN || (lane3IsRestart && !lane3Data && !laneS[3]);
	assign writeOk = s.statusOne[sfpm_pkg::SR1_WEL] && !guardLow && s.bitCnt == 4'h0 && s.byteCnt != 2'h0;

	// Value returned by a read command; it is sampled again at each byte boundary.
	function automatic logic [7:0] readValue(input logic [7:0] op, input sfpm_core_t st);
		logic [7:0] v;
		v = st.statusOne;
		if (op == sfpm_pkg::OP_READ_CONFIG_ONE) begin
			v = st.configOne;
		end else if (op == sfpm_pkg::OP_READ_STATUS_TWO) begin
			v = 8'h00;
			v[sfpm_pkg::SR2_PROG_ERR] = st.progErr;
			v[sfpm_pkg::SR2_ERASE_ERR] = st.eraseErr;
		end
		return v;
	endfunction

	// Merge written bits with held ones; locked bits keep their old value.
	function automatic logic [7:0] merge(input logic [7:0] cur, input logic [7:0] wr, input logic [7:0] keep);
		return (wr & ~keep) | (cur & keep);
	endfunction

	// Output bit counter wraps at each byte.
	function automatic logic [3:0] nextOutCnt(input logic [3:0] cnt, input logic [3:0] st);
		logic [3:0] c;
		c = cnt + st;
		return (c == sfpm_pkg::BITS_PER_BYTE) ? 4'h0 : c;
	endfunction

	// Frame decoder, register updates and the embedded operation flags.
	always_comb begin
		next_s = s;
		next_s.sckPrev = sckS;
		next_s.csPrev = csnS;
		case (s.state)
			sfpm_pkg::ST_IDLE: begin
				// Only a select falling edge opens a frame; a select held low through reset opens one once the synchroniser passes the low level.
				if (csFall) begin
					next_s.state = sfpm_pkg::ST_CMD;
					next_s.bitCnt = 4'h0;
					next_s.byteCnt = 2'h0;
				end
			end
			sfpm_pkg::ST_CMD: begin
				// Opcode bits enter on rising edges, one lane or four.
				if (sckRise) begin
					next_s.shiftIn = shifted;
					next_s.bitCnt = nextCnt;
					if (nextCnt == sfpm_pkg::BITS_PER_BYTE) begin
						next_s.opcode = shifted;
						next_s.bitCnt = 4'h0;
						case (shifted)
							sfpm_pkg::OP_READ_STATUS_ONE, sfpm_pkg::OP_READ_STATUS_TWO,
							sfpm_pkg::OP_READ_CONFIG_ONE: begin
								next_s.state = sfpm_pkg::ST_OUT;
								next_s.shiftOut = readValue(shifted, s);
								next_s.outCnt = 4'h0;
								next_s.laneOut = 4'h0;
							end
							sfpm_pkg::OP_WRITE_REGS: begin
								next_s.state = sfpm_pkg::ST_DATA;
							end
							default: begin
								// Bank-address and autoboot opcodes are unknown here and wait in the done state for the frame to close.
								next_s.state = sfpm_pkg::ST_DONE;
							end
						endcase
					end
				end
			end
			sfpm_pkg::ST_DATA: begin
				// Data bytes of a register write; bytes past the third are dropped.
				if (sckRise) begin
					next_s.shiftIn = shifted;
					next_s.bitCnt = nextCnt;
					if (nextCnt == sfpm_pkg::BITS_PER_BYTE) begin
						next_s.bitCnt = 4'h0;
						case (s.byteCnt)
							2'h0: next_s.dataOne = shifted;
							2'h1: next_s.dataTwo = shifted;
							2'h2: next_s.dataThree = shifted;
							default: next_s.dataThree = s.dataThree;
						endcase
						if (s.byteCnt != sfpm_pkg::MAX_WRITE_BYTES) begin
							next_s.byteCnt = s.byteCnt + 2'h1;
						end
					end
				end
			end
			sfpm_pkg::ST_OUT: begin
				// Output bits change after falling edges; the register repeats while the clock runs.
				if (sckFall) begin
					if (nibble) begin
						next_s.laneOut = s.shiftOut[7:4];
						next_s.shiftOut = {s.shiftOut[3:0], 4'h0};
					end else begin
						next_s.laneOut = {2'h0, s.shiftOut[7], 1'b0};
						next_s.shiftOut = {s.shiftOut[6:0], 1'b0};
					end
					next_s.outCnt = nextOutCnt(s.outCnt, step);
					if (nextOutCnt(s.outCnt, step) == 4'h0) begin
						next_s.shiftOut = readValue(s.opcode, s);
					end
				end
			end
			sfpm_pkg::ST_DONE: begin
				// Opcode taken; wait for the frame to close.
				next_s.state = sfpm_pkg::ST_DONE;
			end
			default: begin
				next_s.state = sfpm_pkg::ST_IDLE;
			end
		endcase
		// Frame end executes the command held; partial opcodes are discarded.
		if (csRise && s.state != sfpm_pkg::ST_IDLE) begin
			next_s.state = sfpm_pkg::ST_IDLE;
			if (s.state == sfpm_pkg::ST_DONE) begin
				case (s.opcode)
					sfpm_pkg::OP_WRITE_ENABLE: next_s.statusOne[sfpm_pkg::SR1_WEL] = 1'b1;
					sfpm_pkg::OP_WRITE_DISABLE: next_s.statusOne[sfpm_pkg::SR1_WEL] = 1'b0;
					sfpm_pkg::OP_CLEAR_STATUS: begin
						// Errors and the stuck busy flag clear, leaving the device in standby.
						next_s.progErr = 1'b0;
						next_s.eraseErr = 1'b0;
						next_s.statusOne[sfpm_pkg::SR1_WIP] = 1'b0;
					end
					default: next_s.opcode = s.opcode;
				endcase
			end
			if (s.state == sfpm_pkg::ST_DATA && s.opcode == sfpm_pkg::OP_WRITE_REGS) begin
				// A held-low guard pin ignores the write without any error.
				if (writeOk) begin
					next_s.statusOne = merge(s.statusOne, s.dataOne,
						sfpm_pkg::SR1_HW_MASK | (s.configOne[sfpm_pkg::CR1_LOCK] ? sfpm_pkg::SR1_LOCK_MASK : 8'h00));
					next_s.statusOneNv = merge(s.statusOneNv, s.dataOne,
						sfpm_pkg::SR1_HW_MASK | (s.configOne[sfpm_pkg::CR1_LOCK] ? sfpm_pkg::SR1_LOCK_MASK : 8'h00));
					// A single byte leaves configuration one, quad bit included, untouched.
					if (s.byteCnt != 2'h1) begin
						next_s.configOne = merge(s.configOne, s.dataTwo,
							s.configOne[sfpm_pkg::CR1_LOCK] ? sfpm_pkg::CR1_LOCK_MASK : 8'h00);
						next_s.configOneNv = merge(s.configOneNv, s.dataTwo,
							s.configOne[sfpm_pkg::CR1_LOCK] ? sfpm_pkg::CR1_LOCK_MASK : 8'h00);
					end
					if (s.byteCnt == sfpm_pkg::MAX_WRITE_BYTES) begin
						next_s.configTwo = s.dataThree;
					end
				end
				next_s.statusOne[sfpm_pkg::SR1_WEL] = 1'b0;
			end
		end
		// Restart drops any frame, reloads status one and configuration one from the nonvolatile copies and configuration two from its reset value.
		if (restartNow) begin
			next_s.state = sfpm_pkg::ST_IDLE;
			next_s.statusOne = s.statusOneNv & ~sfpm_pkg::SR1_HW_MASK;
			next_s.configOne = s.configOneNv;
			next_s.configTwo = sfpm_pkg::CR2_RESET;
			next_s.progErr = 1'b0;
			next_s.eraseErr = 1'b0;
		end
		// Embedded operation flags come last so a new event beats a clear in the same cycle.
		if (opStart) begin
			next_s.statusOne[sfpm_pkg::SR1_WIP] = 1'b1;
			next_s.opErase = opIsErase;
		end
		if (opDone) begin
			if (opFail || opProtected) begin
				// The operation counts as not done: busy stays at one beside the error.
				next_s.progErr = s.progErr | !s.opErase;
				next_s.eraseErr = s.eraseErr | s.opErase;
				next_s.statusOne[sfpm_pkg::SR1_WIP] = 1'b1;
			end else begin
				next_s.statusOne[sfpm_pkg::SR1_WIP] = 1'b0;
			end
		end
	end

	// Register the copy; reset loads the documented defaults.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			s <= '0;
			s.state <= sfpm_pkg::ST_IDLE;
			s.csPrev <= 1'b1;
			s.statusOne <= sfpm_pkg::SR1_RESET;
			s.statusOneNv <= sfpm_pkg::SR1_RESET;
			s.configOne <= sfpm_pkg::CR1_RESET;
			s.configOneNv <= sfpm_pkg::CR1_RESET;
			s.configTwo <= sfpm_pkg::CR2_RESET;
		end else begin
			s <= next_s;
		end
	end

	// Lanes drive only while a read is shifting out and the device is selected.
	always_comb begin
		laneOe = 4'h0;
		if (s.state == sfpm_pkg::ST_OUT && !csnS) begin
			if (nibble) begin
				laneOe = {lane3Data, lane2Data, 2'h3};
			end else begin
				laneOe = 4'h2;
			end
		end
	end

	assign laneOut = s.laneOut;
	assign statusOne = s.statusOne;
	assign configOne = s.configOne;
	assign configTwo = s.configTwo;
	assign progErr = s.progErr;
	assign eraseErr = s.eraseErr;
	assign writeInProgress = s.statusOne[sfpm_pkg::SR1_WIP];
endmodule

// *** core/sfpm_pkg.sv ***
// Constants, opcodes, register layouts and state codes of the serial flash pin-mode and status front end.
package sfpm_pkg;
	// Command opcodes that the decoder understands.
	localparam logic [7:0] OP_WRITE_REGS = 8'h01;
	localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] OP_READ_STATUS_ONE = 8'h05;
	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OP_READ_STATUS_TWO = 8'h07;
	localparam logic [7:0] OP_CLEAR_STATUS = 8'h30;
	localparam logic [7:0] OP_READ_CONFIG_ONE = 8'h35;
	// Status one field positions.
	localparam int SR1_WIP = 0;
	localparam int SR1_WEL = 1;
	localparam int SR1_PROTECT = 7;
	// Configuration one and two field positions.
	localparam int CR1_LOCK = 0;
	localparam int CR1_QUAD = 1;
	localparam int CR2_NIBBLE = 3;
	localparam int CR2_RESTART_EN = 7;
	// Status two field positions for the error flags.
	localparam int SR2_PROG_ERR = 5;
	localparam int SR2_ERASE_ERR = 6;
	// Bits frozen by the lock bit: block protection [5:2] and top/bottom [6], complement [6].
	localparam logic [7:0] SR1_LOCK_MASK = 8'h7c;
	localparam logic [7:0] CR1_LOCK_MASK = 8'h40;
	// Bits of status one that only hardware changes.
	localparam logic [7:0] SR1_HW_MASK = 8'h03;
	// Reset values of the register copies.
	localparam logic [7:0] SR1_RESET = 8'h00;
	localparam logic [7:0] CR1_RESET = 8'h00;
	localparam logic [7:0] CR2_RESET = 8'h80;
	// Shift counts per serial clock edge and per byte.
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] STEP_SINGLE = 4'h1;
	localparam logic [3:0] STEP_NIBBLE = 4'h4;
	localparam logic [1:0] MAX_WRITE_BYTES = 2'h3;
	// Frame states, one-hot.
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_CMD = 5'h02,
		ST_DATA = 5'h04,
		ST_OUT = 5'h08,
		ST_DONE = 5'h10
	} sfpm_state_t;
endpackage

// *** core/sfpm_sync.sv ***
// Three-stage input synchroniser that passes a change once the last two stages agree.
`timescale 1ns/1ps
module sfpm_sync #(
	parameter logic INIT = 1'b1
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic din,
	output logic dout
);
	// All state of the synchroniser.
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic q;
	} sfpm_sync_t;
	sfpm_sync_t s;
	sfpm_sync_t next_s;

	// The first stage feeds only the second, so a metastable value never reaches logic.
	always_comb begin
		next_s = s;
		next_s.s1 = din;
		next_s.s2 = s.s1;
		next_s.s3 = s.s2;
		// A one-cycle glitch between stages two and three is filtered out.
		if (s.s2 == s.s3) begin
			next_s.q = s.s3;
		end
	end

	// Register the copy; reset loads the idle level of the pin.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			s <= {INIT, INIT, INIT, INIT};
		end else begin
			s <= next_s;
		end
	end

	assign dout = s.q;
endmodule

// *** core/sfpm_pin_mux.sv ***
// Function selection of the lane-two and lane-three pins from configuration bits and chip select.
`timescale 1ns/1ps
module sfpm_pin_mux (
	input wire logic quadMode,
	input wire logic nibbleMode,
	input wire logic restartEnable,
	input wire logic protectNv,
	input wire logic csHigh,
	output logic lane2Guard,
	output logic lane2Data,
	output logic lane3Data,
	output logic lane3Restart
);
	// Lane two carries data in quad or nibble mode, which turns its guard off.
	assign lane2Data = quadMode | nibbleMode;
	// Outside those modes it guards register writes once the nonvolatile protect bit is set.
	assign lane2Guard = !quadMode && !nibbleMode && protectNv;
	// Lane three only carries data while the device is selected.
	assign lane3Data = !csHigh && (quadMode || nibbleMode);
	// Otherwise it may serve as restart input, in quad mode only between frames.
	assign lane3Restart = restartEnable && (!quadMode || csHigh);
endmodule

// *** sim/sfpm_checker.sv ***
// Port-level assertions for the serial flash pin-mode and status front end.
`timescale 1ns/1ps
module sfpm_checker (
	input wire logic clk,
	input wire logic resetn,
	input wire logic csnPin,
	input wire logic restartPinN,
	input wire logic [3:0] laneOe,
	input wire logic opStart,
	input wire logic opIsErase,
	input wire logic opDone,
	input wire logic opFail,
	input wire logic opProtected,
	input wire logic [7:0] statusOne,
	input wire logic [7:0] configOne,
	input wire logic [7:0] configTwo,
	input wire logic progErr,
	input wire logic eraseErr,
	input wire logic writeInProgress,
	input wire logic lane2IsGuard,
	input wire logic lane3IsRestart
);
	// Kind of the operation in flight, since the done pulse does not say it.
	logic lastErase;
	// Remember the kind at each start pulse.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			lastErase <= 1'b0;
		end else if (opStart) begin
			lastErase <= opIsErase;
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);
	chk_guard_sel: assert property (
		lane2IsGuard == (!configOne[1] && !configTwo[3] && statusOne[7]))
		else $error("lane two guard selection wrong");
	chk_restart_on: assert property (
		configTwo[7] && !configOne[1] |-> lane3IsRestart)
		else $error("lane three restart missing");
	chk_restart_off: assert property (
		!configTwo[7] |-> !lane3IsRestart)
		else $error("lane three restart while disabled");
	chk_lane_quiet: assert property (
		csnPin [*8] |-> laneOe == 4'h0)
		else $error("lane driven while deselected");
	chk_single_oe: assert property (
		!configTwo[3] |-> laneOe[3:2] == 2'h0 && !laneOe[0])
		else $error("wrong lane driven in single mode");
	chk_err_busy: assert property (
		progErr || eraseErr |-> writeInProgress)
		else $error("busy dropped under an error");
	chk_err_clear: assert property (
		$fell(progErr) || $fell(eraseErr) |-> csnPin)
		else $error("error cleared inside a frame");
	chk_prog_fail: assert property (
		opDone && (opFail || opProtected) && !lastErase |=> progErr && writeInProgress)
		else $error("program fault not flagged");
	chk_erase_fail: assert property (
		opDone && (opFail || opProtected) && lastErase |=> eraseErr && writeInProgress)
		else $error("erase fault not flagged");
	chk_restart_std: assert property (
		!restartPinN [*8] |-> configTwo == 8'h80 && statusOne[1:0] == 2'h0 && !progErr && !eraseErr)
		else $error("restart did not return to standby");
	cov_err_cleared: cover property (progErr ##1 !progErr);
	cov_read_drive: cover property (laneOe[1]);
	cov_restart_sel: cover property (lane3IsRestart ##1 !lane3IsRestart);
	cov_nibble_read: cover property (laneOe == 4'hf);
endmodule

// *** sim/sfpm_host.sv ***
// Host serial controller model that drives the link pins of the flash front end.
`timescale 1ns/1ps
module sfpm_host (
	input wire logic clk,
	input wire logic [3:0] laneOut,
	input wire logic [3:0] laneOe,
	output logic sckPin,
	output logic csnPin,
	output logic [3:0] laneIn
);
	logic d0 = 1'b0; // Serial input level.
	logic t1 = 1'b0; // Lane one when nobody drives it.
	logic l2 = 1'b1; // Guard held firm through every frame.
	logic l3 = 1'b1; // Pull-up level of the restart lane.
	logic [3:0] nb = 4'hf; // Host nibble on all four lanes, idle high so lane three never restarts.
	logic x4 = 1'b0; // Nibble-wide frame in progress.
	// Clock idles low, select idles high.
	initial begin
		sckPin = 1'b0;
		csnPin = 1'b1;
	end
	// Each wire shows the device where it drives, else the host level.
	assign laneIn = (laneOe & laneOut) | (~laneOe & (x4 ? nb : {l3, l2, t1, d0}));
	// A released lane keeps changing, so a stale value cannot pass for read data.
	always @(posedge clk) t1 <= ~t1;
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Select, opcode and data MSB first on lane zero, then deselect; read bits taken at each fall.
	task automatic frame(input logic [7:0] op, input int n, input logic [23:0] wd, output logic [7:0] rd);
		logic [31:0] sh;
		sh = {op, wd};
		rd = 8'h00;
		csnPin <= 1'b0;
		tick(4);
		for (int i = 0; i < 8 * (n + 1); i++) begin
			d0 <= sh[31 - i];
			tick(4);
			sckPin <= 1'b1;
			tick(4);
			rd = {rd[6:0], laneIn[1]};
			sckPin <= 1'b0;
		end
		tick(4);
		csnPin <= 1'b1;
		d0 <= ~d0;
		tick(12);
	endtask
	// Nibble-wide read: opcode high nibble first, then one data byte taken on all lanes before each fall.
	task automatic frame4(input logic [7:0] op, output logic [7:0] rd);
		rd = 8'h00;
		x4 <= 1'b1;
		csnPin <= 1'b0;
		tick(4);
		for (int i = 0; i < 4; i++) begin
			nb <= (i == 0) ? op[7:4] : (i == 1) ? op[3:0] : 4'hf;
			tick(4);
			sckPin <= 1'b1;
			tick(4);
			rd = {rd[3:0], laneIn};
			sckPin <= 1'b0;
		end
		tick(4);
		csnPin <= 1'b1;
		tick(12);
		x4 <= 1'b0;
	endtask
	// Clock and data activity with select high.
	task automatic noise();
		for (int i = 0; i < 16; i++) begin
			d0 <= ~d0;
			sckPin <= ~sckPin;
			tick(2);
		end
	endtask
endmodule

// *** sim/test_serial_flash_pin_mode_status_logic.sv ***
// Self-checking bench for the serial flash pin-mode and status front end.
`timescale 1ns/1ps
module test_serial_flash_pin_mode_status_logic;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic restartPinN = 1'b1;
	logic opStart = 1'b0, opIsErase = 1'b0, opDone = 1'b0, opFail = 1'b0, opProtected = 1'b0;
	logic sckPin, csnPin, progErr, eraseErr, writeInProgress, lane2IsGuard, lane3IsRestart;
	logic [3:0] laneIn, laneOut, laneOe;
	logic [7:0] statusOne, configOne, configTwo, sr, cr, rd, v;
	int error_cnt = 0, check_count = 0, cyc = 0;
	always #12.5 clk = ~clk;
	sfpm_core i_dut (.clk(clk), .resetn(resetn), .sckPin(sckPin), .csnPin(csnPin), .laneIn(laneIn),
		.laneOut(laneOut), .laneOe(laneOe), .restartPinN(restartPinN), .opStart(opStart),
		.opIsErase(opIsErase), .opDone(opDone), .opFail(opFail), .opProtected(opProtected),
		.statusOne(statusOne), .configOne(configOne), .configTwo(configTwo), .progErr(progErr),
		.eraseErr(eraseErr), .writeInProgress(writeInProgress), .lane2IsGuard(lane2IsGuard),
		.lane3IsRestart(lane3IsRestart));
	sfpm_host i_host (.clk(clk), .laneOut(laneOut), .laneOe(laneOe), .sckPin(sckPin), .csnPin(csnPin),
		.laneIn(laneIn));
	// Status after a write: locked fields keep the old value, hardware bits read zero.
	function automatic logic [7:0] expSr(input logic [7:0] old, input logic [7:0] val, input logic lk);
		return ((lk ? old : val) & sfpm_pkg::SR1_LOCK_MASK) | (val & ~sfpm_pkg::SR1_LOCK_MASK & ~sfpm_pkg::SR1_HW_MASK);
	endfunction
	function automatic logic [7:0] expCr(input logic [7:0] old, input logic [7:0] val, input logic lk);
		return ((lk ? old : val) & sfpm_pkg::CR1_LOCK_MASK) | (val & ~sfpm_pkg::CR1_LOCK_MASK);
	endfunction
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wrap_up();
		$display("checks=%0d mismatches=%0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic doneTest(input string s);
		$display("test %s done", s);
	endtask
	// Enabled register write of n bytes; the lock seen is the one before the write.
	task automatic wr(input int n, input logic [23:0] d);
		logic lk;
		lk = cr[0];
		i_host.frame(sfpm_pkg::OP_WRITE_ENABLE, 0, 24'h0, rd);
		i_host.frame(sfpm_pkg::OP_WRITE_REGS, n, d, rd);
		if (n > 1) cr = expCr(cr, d[15:8], lk);
		sr = expSr(sr, d[23:16], lk);
		chk8(statusOne, sr);
		chk8(configOne, cr);
	endtask
	// One array operation: start pulse, then a qualified done pulse.
	task automatic engine(input logic e, input logic f, input logic p);
		opStart <= 1'b1;
		opIsErase <= e;
		@(posedge clk);
		opStart <= 1'b0;
		repeat (3) @(posedge clk);
		opDone <= 1'b1;
		opFail <= f;
		opProtected <= p;
		@(posedge clk);
		opDone <= 1'b0;
		opFail <= 1'b0;
		opProtected <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	// Restart through lane three or the dedicated pin, select high.
	task automatic pulse(input logic lane3);
		if (lane3) i_host.l3 <= 1'b0;
		else restartPinN <= 1'b0;
		repeat (10) @(posedge clk);
		i_host.l3 <= 1'b1;
		restartPinN <= 1'b1;
		repeat (6) @(posedge clk);
	endtask
	// Cut a hang short.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			wrap_up();
		end
	end
	// Main sequence.
	initial begin
		void'($urandom(13));
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		repeat (6) @(posedge clk);
		sr = 8'h00;
		cr = 8'h00;
		chk8(statusOne, 8'h00);
		chk8(configTwo, 8'h80);
		chk8({2'h0, laneOe, progErr, eraseErr}, 8'h00);
		doneTest("reset");
		for (int i = 0; i < 8; i++) begin
			v = 8'($urandom);
			wr(2, {v, 1'b0, 1'($urandom), 5'h00, i[1], 8'h00});
			i_host.frame(sfpm_pkg::OP_READ_STATUS_ONE, 1, 24'h0, rd);
			chk8(rd, sr);
			i_host.frame(sfpm_pkg::OP_READ_CONFIG_ONE, 1, 24'h0, rd);
			chk8(rd, cr);
		end
		doneTest("write and read");
		wr(2, {sr, cr | 8'h02, 8'h00});
		chk8({6'h0, lane2IsGuard, lane3IsRestart}, 8'h01);
		wr(1, {8'($urandom), 16'h0});
		wr(2, {sr, cr & 8'hfd, 8'h00});
		doneTest("quad");
		i_host.frame(8'h17, 1, 24'hff0000, rd);
		i_host.frame(8'hb7, 0, 24'h0, rd);
		i_host.noise();
		chk8(statusOne, sr);
		chk8(configOne, cr);
		doneTest("ignored");
		// A write after write disable, then one under a held-low guard: both leave the registers alone.
		i_host.frame(sfpm_pkg::OP_WRITE_ENABLE, 0, 24'h0, rd);
		i_host.frame(sfpm_pkg::OP_WRITE_DISABLE, 0, 24'h0, rd);
		i_host.frame(sfpm_pkg::OP_WRITE_REGS, 1, {~sr, 16'h0}, rd);
		chk8(statusOne, sr);
		wr(1, {sr | 8'h80, 16'h0});
		chk8({7'h0, lane2IsGuard}, 8'h01);
		i_host.l2 <= 1'b0;
		i_host.frame(sfpm_pkg::OP_WRITE_ENABLE, 0, 24'h0, rd);
		i_host.frame(sfpm_pkg::OP_WRITE_REGS, 2, {~sr, ~cr, 8'h00}, rd);
		i_host.l2 <= 1'b1;
		chk8(statusOne, sr);
		chk8(configOne, cr);
		doneTest("guard");
		engine(1'b0, 1'b1, 1'b0);
		repeat (20) @(posedge clk);
		chk8({6'h0, progErr, writeInProgress}, 8'h03);
		i_host.frame(sfpm_pkg::OP_READ_STATUS_TWO, 1, 24'h0, rd);
		chk8(rd, 8'(1 << sfpm_pkg::SR2_PROG_ERR));
		i_host.frame(sfpm_pkg::OP_CLEAR_STATUS, 0, 24'h0, rd);
		chk8({6'h0, progErr, writeInProgress}, 8'h00);
		engine(1'b1, 1'b0, 1'b1);
		chk8({6'h0, eraseErr, writeInProgress}, 8'h03);
		i_host.frame(sfpm_pkg::OP_READ_STATUS_TWO, 1, 24'h0, rd);
		chk8(rd, 8'(1 << sfpm_pkg::SR2_ERASE_ERR));
		pulse(1'b0);
		chk8({6'h0, eraseErr, writeInProgress}, 8'h00);
		chk8(statusOne, sr);
		doneTest("errors");
		wr(3, {sr, cr, 8'h00});
		chk8(configTwo, 8'h00);
		engine(1'b0, 1'b0, 1'b1);
		pulse(1'b1);
		chk8({6'h0, progErr, lane3IsRestart}, 8'h02);
		pulse(1'b0);
		engine(1'b0, 1'b1, 1'b0);
		pulse(1'b1);
		chk8({progErr, configTwo[6:0]}, 8'h00);
		// Nibble mode: guard off, lane three data while selected, then restart through lane three.
		wr(3, {sr, cr, 8'h88});
		chk8({6'h0, lane2IsGuard, lane3IsRestart}, 8'h01);
		i_host.frame4(sfpm_pkg::OP_READ_STATUS_ONE, rd);
		chk8(rd, sr);
		pulse(1'b1);
		chk8(configTwo, 8'h80);
		doneTest("restart select");
		wrap_up();
	end
endmodule
bind sfpm_core sfpm_checker i_chk (.clk(clk), .resetn(resetn), .csnPin(csnPin), .restartPinN(restartPinN),
	.laneOe(laneOe), .opStart(opStart), .opIsErase(opIsErase), .opDone(opDone), .opFail(opFail),
	.opProtected(opProtected), .statusOne(statusOne), .configOne(configOne), .configTwo(configTwo),
	.progErr(progErr), .eraseErr(eraseErr), .writeInProgress(writeInProgress),
	.lane2IsGuard(lane2IsGuard), .lane3IsRestart(lane3IsRestart));
